// ---- design/pph_top.sv ----
/*
 * set-point handshake and sequencing for profile position operation:
 * strobe edge detection, target queue, immediate and pass-through switching,
 * halt and resume, range supervision and status word.
 * assumes command word, target and feedback come from logic on mclk;
 * only the limit switch pins come from outside and are synchronised.
 */
`timescale 1ns/1ps
module pph_top (
  // clock, reset, enable
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic               clk_en,
  // controller command side
  input  wire logic [15:0]        motion_command_word,
  input  wire logic signed [31:0] target_position,
  input  wire logic [7:0]         operating_mode,
  input  wire logic               operation_enabled,
  // supervision settings
  input  wire logic signed [31:0] soft_limit_min,
  input  wire logic signed [31:0] soft_limit_max,
  input  wire logic [31:0]        position_window,
  input  wire logic [15:0]        window_time_cycles,
  input  wire logic [31:0]        tracking_window,
  // profile generator and position loop feedback
  input  wire logic signed [31:0] demand_position,
  input  wire logic signed [31:0] actual_position,
  input  wire logic               demand_done,
  input  wire logic               axis_standstill,
  // limit switch pins
  input  wire logic               limit_pos_pin,
  input  wire logic               limit_neg_pin,
  // status back to controller
  output logic [15:0]             motion_status_word,
  // orders to profile generator
  output logic signed [31:0]      move_target,
  output logic                    move_start,
  output logic                    move_blend,
  output logic                    move_halt
);

  // command fields
  logic cmd_new;        // new-target strobe level
  logic cmd_immediate;  // immediate switch
  logic cmd_relative;   // relative select
  logic cmd_halt;       // halt command
  logic cmd_pass;       // pass-through

  assign cmd_new       = motion_command_word[pph_pkg::CMD_NEW_TARGET];
  assign cmd_immediate = motion_command_word[pph_pkg::CMD_IMMEDIATE];
  assign cmd_relative  = motion_command_word[pph_pkg::CMD_RELATIVE];
  assign cmd_halt      = motion_command_word[pph_pkg::CMD_HALT];
  assign cmd_pass      = motion_command_word[pph_pkg::CMD_PASS];

  // state
  pph_pkg::pph_state_t          state;         // sequencer state
  logic                         strobe_prev;   // strobe one cycle ago
  logic                         halt_prev;     // halt one cycle ago
  logic signed [31:0]           last_target;   // base for relative targets
  logic [2:0]                   q_count;       // queued targets
  logic [pph_pkg::QUEUE_ADDR_W-1:0] q_wr;      // queue write pointer
  logic [pph_pkg::QUEUE_ADDR_W-1:0] q_rd;      // queue read pointer
  logic                         q_busy;        // read data settling
  logic [pph_pkg::ENTRY_W-1:0]  q_head;        // registered head entry
  logic                         accepted;      // accepted status bit
  logic                         limit_active;  // range stop latched
  logic [1:0]                   sync_a;        // first synchroniser stage
  logic [1:0]                   sync_b;        // synchronised limit pins
  logic                         settled;       // dwell done

  // decode
  logic                         mode_ok;       // mode selected and enabled
  logic                         strobe_rise;   // qualified rising edge
  logic                         q_full;        // no free slot
  logic                         take;          // a target is accepted
  logic                         go_direct;     // accepted target starts now
  logic                         push;          // accepted target queued
  logic                         head_ok;       // head entry usable
  logic                         pop;           // head entry starts now
  logic                         resume;        // halt withdrawn mid move
  logic                         limit_hit;     // move runs into a limit
  logic signed [31:0]           raw_target;    // target before clamping
  logic signed [31:0]           next_target;   // clamped absolute target
  logic                         next_reached;  // goal arrived status

  assign mode_ok = (operating_mode == pph_pkg::MODE_PROFILE_POSITION) && operation_enabled;

  // edge detect
  // a rise is the strobe high now and low on the previous sample
  assign strobe_rise = cmd_new && !strobe_prev && mode_ok;

  // full queue
  // a rise that finds no free slot is dropped
  assign q_full = (q_count == 3'(pph_pkg::QUEUE_SLOTS));
  assign take   = strobe_rise && !q_full;

  // direct start
  // idle with nothing queued, or immediate switch, starts at once
  assign go_direct = take && (cmd_immediate || (state == pph_pkg::PPH_IDLE && q_count == 3'h0));
  assign push      = take && !go_direct;

  // queue advance
  // plain entries wait for idle, pass-through entries leave at demand end
  assign head_ok = (q_count != 3'h0) && !q_busy && !go_direct && !limit_hit;
  assign pop     = head_ok && !cmd_halt &&
                   ((state == pph_pkg::PPH_IDLE) ||
                    (q_head[pph_pkg::POS_W] && demand_done));

  // resume
  // withdrawing halt restarts toward the target still held
  assign resume = halt_prev && !cmd_halt && (state != pph_pkg::PPH_IDLE) && !pop;

  // range stop
  // a switch in the direction of travel ends the move
  assign limit_hit = (state != pph_pkg::PPH_IDLE) &&
                     ((sync_b[0] && (move_target > actual_position)) ||
                      (sync_b[1] && (move_target < actual_position)));

  // relative target
  // relative values add to the last accepted target
  assign raw_target = cmd_relative ? 32'(last_target + target_position) : target_position;

  // software limits
  // targets are clamped into the permitted range
  always_comb begin
    if (raw_target > soft_limit_max) begin
      next_target = soft_limit_max;
    end else if (raw_target < soft_limit_min) begin
      next_target = soft_limit_min;
    end else begin
      next_target = raw_target;
    end
  end

  // limit switch synchronisers, one per pin
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
      end else if (clk_en) begin
        sync_a[i] <= (i == 0) ? limit_pos_pin : limit_neg_pin;
        sync_b[i] <= sync_a[i];
      end
    end
  end

  // previous samples of strobe and halt
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      strobe_prev <= 1'b0;
      halt_prev   <= 1'b0;
    end else if (clk_en) begin
      strobe_prev <= cmd_new;
      halt_prev   <= cmd_halt && mode_ok;
    end
  end

  // last accepted target, base of relative moves
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      last_target <= pph_pkg::TARGET_RESET;
    end else if (clk_en && take) begin
      last_target <= next_target;
    end
  end

  // queue pointers
  // up to three entries wait behind the running move
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q_count <= 3'h0;
      q_wr    <= '0;
      q_rd    <= '0;
      q_busy  <= 1'b0;
    end else if (clk_en) begin
      q_busy <= push || pop || go_direct || limit_hit;
      if ((go_direct && cmd_immediate) || limit_hit) begin
        // immediate switch or range stop discards the queue
        q_count <= 3'h0;
        q_wr    <= '0;
        q_rd    <= '0;
      end else begin
        if (push) begin
          q_wr <= q_wr + 2'h1;
        end
        if (pop) begin
          q_rd <= q_rd + 2'h1;
        end
        q_count <= q_count + 3'(push) - 3'(pop);
      end
    end
  end

  // target queue storage
  pph_queue_mem u_queue (
    .mclk    (mclk),
    .reset   (reset),
    .clk_en  (clk_en),
    .wr_en   (push),
    .wr_addr (q_wr),
    .wr_data ({cmd_pass, next_target}),
    .rd_addr (q_rd),
    .rd_data (q_head)
  );

  // sequencer
  // a move ends through demand done and the dwell, or at once on a range stop or when mode_ok drops
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state <= pph_pkg::PPH_IDLE;
    end else if (clk_en) begin
      if (go_direct || pop) begin
        state <= pph_pkg::PPH_MOVE;
      end else if (limit_hit || !mode_ok) begin
        state <= pph_pkg::PPH_IDLE;
      end else begin
        unique case (state)
          pph_pkg::PPH_IDLE: begin
            state <= pph_pkg::PPH_IDLE;
          end
          pph_pkg::PPH_MOVE: begin
            // profile finished and not halted
            if (demand_done && !cmd_halt) begin
              state <= pph_pkg::PPH_SETTLE;
            end
          end
          pph_pkg::PPH_SETTLE: begin
            if (settled) begin
              state <= pph_pkg::PPH_IDLE;
            end else if (cmd_halt) begin
              state <= pph_pkg::PPH_MOVE;
            end
          end
        endcase
      end
    end
  end

  // dwell inside the position window
  pph_settle u_settle (
    .mclk               (mclk),
    .reset              (reset),
    .clk_en             (clk_en),
    .arm                (state == pph_pkg::PPH_SETTLE),
    .actual_position    (actual_position),
    .goal_position      (move_target),
    .position_window    (position_window),
    .window_time_cycles (window_time_cycles),
    .settled            (settled)
  );

  // orders to the profile generator
  // start pulses carry the target and the blend choice
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      move_target <= pph_pkg::TARGET_RESET;
      move_start  <= 1'b0;
      move_blend  <= 1'b0;
      move_halt   <= 1'b0;
    end else if (clk_en) begin
      move_start <= go_direct || pop || resume;
      move_halt  <= (cmd_halt && mode_ok) || limit_hit;
      if (go_direct) begin
        move_target <= next_target;
        move_blend  <= 1'b0;
      end else if (pop) begin
        move_target <= q_head[pph_pkg::POS_W-1:0];
        move_blend  <= q_head[pph_pkg::POS_W];
      end
    end
  end

  // accepted bit
  // set on load, cleared once strobe is low and a slot is free
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      accepted <= 1'b0;
    end else if (clk_en) begin
      if (take) begin
        accepted <= 1'b1;
      end else if (!cmd_new && !q_full) begin
        accepted <= 1'b0;
      end
    end
  end

  // range flag
  // held until the next accepted target
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      limit_active <= 1'b0;
    end else if (clk_en) begin
      if (limit_hit) begin
        limit_active <= 1'b1;
      end else if (take) begin
        limit_active <= 1'b0;
      end
    end
  end

  // goal arrived
  // halt reports standstill, otherwise idle with nothing queued
  always_comb begin
    if (cmd_halt && mode_ok) begin
      next_reached = axis_standstill;
    end else begin
      next_reached = (state == pph_pkg::PPH_IDLE) && (q_count == 3'h0) && !go_direct;
    end
  end

  // status word
  // tracking fault follows the demand-to-actual deviation
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      motion_status_word <= pph_pkg::STATUS_RESET;
    end else if (clk_en) begin
      motion_status_word <= '0;
      motion_status_word[pph_pkg::STS_REACHED]  <= next_reached;
      motion_status_word[pph_pkg::STS_LIMIT]    <= limit_active || limit_hit;
      motion_status_word[pph_pkg::STS_ACCEPTED] <= take || (accepted && (cmd_new || q_full));
      motion_status_word[pph_pkg::STS_TRACKING] <=
        pph_pkg::abs_diff(demand_position, actual_position) > tracking_window;
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_edge_accept: assert property (
    clk_en && strobe_rise && !q_full |=> motion_status_word[pph_pkg::STS_ACCEPTED])
    else $error("accepted edge not acknowledged");
  a_idle_no_start: assert property (
    clk_en && state == pph_pkg::PPH_IDLE && q_count == 3'h0 && !strobe_rise |=> !move_start)
    else $error("start without strobe edge");
  a_wait_keep_target: assert property (
    clk_en && take && !cmd_immediate && state != pph_pkg::PPH_IDLE && !pop
    |=> move_target == $past(move_target))
    else $error("queued target replaced running one");
  a_immediate_switch: assert property (
    clk_en && take && cmd_immediate
    |=> move_start && move_target == $past(next_target) && q_count == 3'h0)
    else $error("immediate switch not taken");
  a_relative_base: assert property (
    clk_en && take |=> last_target == $past(next_target))
    else $error("relative base not updated");
  a_queue_bound: assert property (
    q_count <= 3'(pph_pkg::QUEUE_SLOTS))
    else $error("queue over three");
  a_full_hold_ack: assert property (
    clk_en && q_full && accepted && !pop && !limit_hit |=> accepted ##0 q_count == 3'h3)
    else $error("full queue lost accepted bit");
  a_halt_status: assert property (
    clk_en && cmd_halt && mode_ok
    |=> motion_status_word[pph_pkg::STS_REACHED] == $past(axis_standstill))
    else $error("halt arrival not standstill");
  a_tracking_flag: assert property (
    clk_en && pph_pkg::abs_diff(demand_position, actual_position) > tracking_window
    |=> motion_status_word[pph_pkg::STS_TRACKING])
    else $error("tracking fault missed");

  c_immediate: cover property (clk_en && take && cmd_immediate && state != pph_pkg::PPH_IDLE);
  c_blend_pop: cover property (clk_en && pop && q_head[pph_pkg::POS_W]);
  c_queue_full: cover property (clk_en && q_full && strobe_rise);
  c_resume: cover property (clk_en && resume ##1 move_start);

endmodule

// ---- design/pph_pkg.sv ----
/*
 * package for the profile position set-point handshake block: command and
 * status bit positions, mode value, queue sizing, reset values and helpers.
 * assumes it is compiled before every design file that names it.
 */
package pph_pkg;

  // command word bit positions
  localparam int CMD_NEW_TARGET = 4;   // new-target strobe
  localparam int CMD_IMMEDIATE  = 5;   // immediate switch
  localparam int CMD_RELATIVE   = 6;   // relative select
  localparam int CMD_HALT       = 8;   // halt command
  localparam int CMD_PASS       = 9;   // pass-through at target

  // status word bit positions
  localparam int STS_REACHED    = 10;  // goal arrived
  localparam int STS_LIMIT      = 11;  // range limit active
  localparam int STS_ACCEPTED   = 12;  // target accepted
  localparam int STS_TRACKING   = 13;  // tracking fault

  // operating mode value that selects profile position operation
  localparam logic [7:0] MODE_PROFILE_POSITION = 8'h01;

  // target queue sizing
  localparam int QUEUE_SLOTS      = 3;   // further targets held
  localparam int QUEUE_ADDR_W     = 2;   // memory address width
  localparam int QUEUE_DEPTH      = 4;   // memory entries
  localparam int POS_W            = 32;  // position width
  localparam int ENTRY_W          = 33;  // position plus pass-through flag

  // reset values
  localparam logic [15:0] STATUS_RESET = 16'h0400;  // idle: goal arrived
  localparam logic [31:0] TARGET_RESET = 32'h00000000;
  localparam logic [15:0] DWELL_RESET  = 16'h0000;

  // operating states of the movement sequencer
  typedef enum logic [1:0] {
    PPH_IDLE,
    PPH_MOVE,
    PPH_SETTLE
  } pph_state_t;

  // magnitude of the difference of two signed positions
  function automatic logic [31:0] abs_diff(input logic signed [31:0] a,
                                           input logic signed [31:0] b);
    logic signed [31:0] d;
    d = a - b;
    abs_diff = d[31] ? 32'(-d) : 32'(d);
  endfunction

endpackage

// ---- design/pph_queue_mem.sv ----
/*
 * small memory that holds queued targets with their pass-through flag.
 * assumes one writer and one reader on mclk; read data are registered,
 * so a just written entry is readable two edges later.
 */
`timescale 1ns/1ps
module pph_queue_mem (
  // clock and reset
  input  wire logic                         mclk,
  input  wire logic                         reset,
  input  wire logic                         clk_en,
  // write side
  input  wire logic                         wr_en,
  input  wire logic [pph_pkg::QUEUE_ADDR_W-1:0] wr_addr,
  input  wire logic [pph_pkg::ENTRY_W-1:0]  wr_data,
  // read side
  input  wire logic [pph_pkg::QUEUE_ADDR_W-1:0] rd_addr,
  output logic      [pph_pkg::ENTRY_W-1:0]  rd_data
);

  // storage array, no reset needed for data
  logic [pph_pkg::ENTRY_W-1:0] mem [pph_pkg::QUEUE_DEPTH];

  // write port
  always_ff @(posedge mclk) begin
    if (clk_en && wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // registered read port
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else if (clk_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ---- design/pph_settle.sv ----
/*
 * dwell timer: reports arrival once the actual position has stayed inside
 * the position window for the window time while armed.
 * assumes positions and settings come from logic on mclk.
 */
`timescale 1ns/1ps
module pph_settle (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic               clk_en,
  // control
  input  wire logic               arm,
  // positions and window
  input  wire logic signed [31:0] actual_position,
  input  wire logic signed [31:0] goal_position,
  input  wire logic [31:0]        position_window,
  input  wire logic [15:0]        window_time_cycles,
  // result
  output logic                    settled
);

  logic [15:0] dwell;      // cycles spent inside the window
  logic        in_window;  // axis inside the window this cycle

  assign in_window = pph_pkg::abs_diff(actual_position, goal_position) <= position_window;

  // dwell counter, restarts whenever the axis leaves the window
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dwell   <= pph_pkg::DWELL_RESET;
      settled <= 1'b0;
    end else if (clk_en) begin
      if (!arm || !in_window) begin
        // out of window or not waiting
        dwell   <= pph_pkg::DWELL_RESET;
        settled <= 1'b0;
      end else if (dwell >= window_time_cycles) begin
        // window time has elapsed
        settled <= 1'b1;
      end else begin
        dwell <= dwell + 16'h0001;
      end
    end
  end

endmodule

// ---- dv/pph_axis_model.sv ----
/*
 * axis model: profile generator and mechanics behind the block.
 * assumes move orders from pph_top on the same mclk.
 */
`timescale 1ns/1ps
module pph_axis_model (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // orders
  input  wire logic signed [31:0] move_target,
  input  wire logic               move_halt,
  // feedback
  output logic signed [31:0]      position,
  output logic                    demand_done,
  output logic                    axis_standstill
);
  logic halt_q; // brakes need one cycle before standstill
  // step four counts a cycle toward the target unless halted
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      position <= '0;
      halt_q   <= 1'b0;
    end else begin
      halt_q <= move_halt;
      if (!move_halt && position != move_target)
        position <= (move_target - position > 4) ? position + 4 :
                    (position - move_target > 4) ? position - 4 : move_target;
    end
  end
  assign demand_done     = (position == move_target);
  assign axis_standstill = demand_done || (move_halt && halt_q);
endmodule

// ---- dv/tb_top.sv ----
/*
 * self-checking bench for pph_top, axis model on the far side.
 * assumes the design package and design files are compiled first.
 */
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin err_total++; \
  $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  logic               mclk, reset;   // clock and reset
  logic [15:0]        cw, sts;       // command and status words
  logic [7:0]         mode;          // operating mode
  logic signed [31:0] tgt, mtgt, pos; // positions
  logic               mstart, mblend, mhalt, ddone, still;
  logic signed [31:0] a, b, c;       // scratch targets
  logic signed [31:0] q [3];         // queued targets
  logic               ce, en, lp, ln; // enable, operation enabled, limit pins
  logic signed [31:0] dofs;          // demand offset to provoke a tracking fault
  int                 err_total, n_checks;

  pph_top i_dut (.mclk(mclk), .reset(reset), .clk_en(ce), .motion_command_word(cw),
    .target_position(tgt), .operating_mode(mode), .operation_enabled(en),
    .soft_limit_min(-32'sh10000), .soft_limit_max(32'sh10000),
    .position_window(32'h2), .window_time_cycles(16'h4), .tracking_window(32'h64),
    .demand_position(pos + dofs), .actual_position(pos), .demand_done(ddone),
    .axis_standstill(still), .limit_pos_pin(lp), .limit_neg_pin(ln),
    .motion_status_word(sts), .move_target(mtgt), .move_start(mstart),
    .move_blend(mblend), .move_halt(mhalt));

  pph_axis_model i_axis (.mclk(mclk), .reset(reset), .move_target(mtgt),
    .move_halt(mhalt), .position(pos), .demand_done(ddone), .axis_standstill(still));

  // expected goal of a relative move: offset on the last accepted target
  function automatic logic signed [31:0] rel_goal(logic signed [31:0] base,
                                                  logic signed [31:0] off);
    return base + off;
  endfunction

  // pass edges, then settle
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  // raise strobe with option bits, check the answer, drop it after ack
  task automatic strobe(logic [15:0] opt, logic signed [31:0] v, logic go,
                        logic signed [31:0] ex);
    @(posedge mclk);
    cw  <= opt | 16'h0010;
    tgt <= v;
    step(1);
    `CHK("ack", 1'b1, sts[12])
    `CHK("start", go, mstart)
    `CHK("target", ex, mtgt)
    @(posedge mclk);
    cw <= opt;
    step(1);
  endtask

  // wait for arrival, bounded
  task automatic arrive(logic signed [31:0] ex);
    for (int i = 0; i < 4000 && sts[10] !== 1'b1; i++) step(1);
    `CHK("arrived", 1'b1, sts[10])
    `CHK("final", ex, mtgt)
    `CHK("fault", 1'b0, sts[13])
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // free running clock
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // watchdog
  initial begin
    repeat (60000) @(posedge mclk);
    err_total++;
    final_report();
  end

  // main sequence
  initial begin
    reset = 1'b1;
    cw = '0;
    tgt = '0;
    mode = 8'h01;
    ce = 1'b1;
    en = 1'b1;
    lp = 1'b0;
    ln = 1'b0;
    dofs = '0;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'hF78B));
    step(16);
    `CHK("rst_status", 16'h0400, sts)
    @(posedge mclk);
    reset <= 1'b0;
    step(2);
    // strobe in a wrong mode is ignored
    @(posedge mclk);
    mode <= 8'h00;
    cw   <= 16'h0010;
    step(3);
    `CHK("mode_ack", 1'b0, sts[12])
    `CHK("mode_start", 1'b0, mstart)
    @(posedge mclk);
    mode <= 8'h01;
    cw   <= '0;
    step(1);
    // strobe while operation is not enabled is ignored
    @(posedge mclk);
    en <= 1'b0;
    cw <= 16'h0010;
    step(3);
    `CHK("enable_ack", 1'b0, sts[12])
    @(posedge mclk);
    en <= 1'b1;
    cw <= '0;
    step(1);
    // plain start from idle
    a = $urandom_range(400, 100);
    strobe(16'h0000, a, 1'b1, a);
    arrive(a);
    // immediate switch mid move
    strobe(16'h0000, a + 2000, 1'b1, a + 2000);
    step(20);
    c = $urandom_range(300, 0);
    strobe(16'h0020, c, 1'b1, c);
    arrive(c);
    // three queued, a fourth refused
    a = c + 1600;
    strobe(16'h0000, a, 1'b1, a);
    foreach (q[i]) begin
      q[i] = $urandom_range(500, 0);
      strobe(16'h0000, q[i], 1'b0, a);
    end
    strobe(16'h0000, 32'sh7777, 1'b0, a);
    arrive(q[2]);
    // relative to last accepted target
    b = $urandom_range(200, 1);
    strobe(16'h0040, b, 1'b1, rel_goal(q[2], b));
    arrive(rel_goal(q[2], b));
    // pass-through blend
    a = q[2] + b + 1200;
    strobe(16'h0000, a, 1'b1, a);
    c = $urandom_range(300, 0);
    strobe(16'h0200, c, 1'b0, a);
    arrive(c);
    `CHK("blend", 1'b1, mblend)
    // halt mid move, then resume
    a = c + 2000;
    strobe(16'h0000, a, 1'b1, a);
    step(10);
    @(posedge mclk);
    cw <= 16'h0100;
    step(2);
    `CHK("halt", 1'b1, mhalt)
    for (int i = 0; i < 50 && sts[10] !== 1'b1; i++) step(1);
    `CHK("standstill", 1'b1, sts[10])
    `CHK("held", a, mtgt)
    @(posedge mclk);
    cw <= 16'h0000;
    step(4);
    `CHK("resumed", 1'b0, sts[10])
    arrive(a);
    // limit switch in the direction of travel stops the move
    strobe(16'h0000, a + 2000, 1'b1, a + 2000);
    step(10);
    @(posedge mclk);
    lp <= 1'b1;
    step(4);
    `CHK("limit", 1'b1, sts[11])
    @(posedge mclk);
    lp <= 1'b0;
    strobe(16'h0000, a, 1'b1, a);
    `CHK("limit_clear", 1'b0, sts[11])
    arrive(a);
    // demand running away from actual raises the tracking fault
    @(posedge mclk);
    dofs <= $urandom_range(400, 101);
    step(2);
    `CHK("tracking", 1'b1, sts[13])
    @(posedge mclk);
    dofs <= '0;
    step(2);
    `CHK("tracking_clear", 1'b0, sts[13])
    final_report();
  end
endmodule
